// >>> logic/kbn_consts.vh
// constants for the keyboard scan and nmi control block
`ifndef KBN_CONSTS_VH
`define KBN_CONSTS_VH

// index register offsets
`define KBN_IDX_SENSE_C 8'h65
`define KBN_IDX_SCAN_SETUP 8'h66
`define KBN_IDX_NMI_CTRL 8'h67
`define KBN_IDX_SHADOW 8'h68

// legacy i/o port offsets (low byte of the i/o address)
`define KBN_IO_DATA_PORT 8'h60
`define KBN_IO_CTRL_PORT 8'h61
`define KBN_IO_SWITCH_PORT 8'h62

// keyboard_scan_setup fields
`define KBN_SW_HI 7
`define KBN_SW_LO 4
`define KBN_PRIMARY_BIT 3
`define KBN_SCAN_TYPE_BIT 2
`define KBN_RATE_HI 1
`define KBN_RATE_LO 0

// nmi_control_status fields
`define KBN_KEY_FLAG_BIT 7
`define KBN_PER_FLAG_BIT 6
`define KBN_CTRL_FLAG_BIT 5
`define KBN_KEY_EN_BIT 3
`define KBN_PER_EN_BIT 2
`define KBN_CTRL_EN_BIT 1

// key_control_port fields
`define KBN_KCLK_EN_BIT 6

// reset values
`define KBN_SETUP_RST 8'h00
`define KBN_NMI_RST 8'h00
`define KBN_SHADOW_RST 8'h00
`define KBN_DATA_RST 8'h00
`define KBN_CTRL_RST 8'h00
`define KBN_SENSE_C_RST 8'hFF
`define KBN_UNMAPPED_RD 8'h00

// timing: clock rate and periodic nmi rates in hz
`define KBN_MCLK_HZ 200000000
`define KBN_RATE0_HZ 51
`define KBN_RATE1_HZ 64
`define KBN_RATE2_HZ 85
`define KBN_RATE3_HZ 128
`define KBN_RATE0_CYC (`KBN_MCLK_HZ / `KBN_RATE0_HZ)
`define KBN_RATE1_CYC (`KBN_MCLK_HZ / `KBN_RATE1_HZ)
`define KBN_RATE2_CYC (`KBN_MCLK_HZ / `KBN_RATE2_HZ)
`define KBN_RATE3_CYC (`KBN_MCLK_HZ / `KBN_RATE3_HZ)

// serial keyboard frame: start bit then data bits
`define KBN_RX_BITS 8

`endif

// >>> logic/kbn_keyboard_scan_nmi_control.v
// keyboard source select, matrix keydown detect and nmi generation
// Functional notes
// - sense status C: live assigned pins, else one
// - config switches stored, shown on switch port
// - serial primary: data port read-only, serial byte
// - serial primary: irq after one full character
// - matrix primary: data port rw, write raises irq
// - matrix primary: serial byte to shadow, no irq
// - scan type picks sense or drive keydown
// - rate field picks 51/64/85/128 Hz
// - periodic source runs always; nmi needs enable
// - keydown flag reads one while keydown nmi active
// - keydown enable resets zero, gates keydown source
// - keydown is level, nmi held while key down
// - bit7 write clears keydown unless key still down
// - bit6 write one clears periodic flag
// - bit5 write one clears control-write flag
// - periodic enable resets zero, issues periodic nmi
// - control port bit6 rising write raises nmi
// - clock enable low holds keyboard clock low
// - serial primary: shadow holds last data write
`timescale 1ns/10ps
`include "kbn_consts.vh"
module kbn_keyboard_scan_nmi_control
#(
  parameter LINES = 24,
  parameter RATE0_CYC = `KBN_RATE0_CYC,
  parameter RATE1_CYC = `KBN_RATE1_CYC,
  parameter RATE2_CYC = `KBN_RATE2_CYC,
  parameter RATE3_CYC = `KBN_RATE3_CYC
)
(
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // register access: index registers or legacy i/o ports
  input wire io_space_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  // keyboard matrix lines and their pin assignment
  input wire [LINES-1:0] sense_lines_i,
  input wire [LINES-1:0] sense_assign_i,
  input wire [LINES-1:0] drive_lines_i,
  input wire [LINES-1:0] drive_assign_i,
  // serial keyboard pins
  input wire serial_kbd_clk_i,
  output wire serial_kbd_clk_o,
  output wire serial_kbd_clk_oe_o,
  input wire serial_kbd_data_i,
  // interrupt outputs
  output reg keyboard_irq_o,
  output wire nmi_o
);

  // register state
  reg [7:0] scan_setup;
  reg en_key;
  reg en_per;
  reg en_ctrl;
  reg flag_key;
  reg flag_per;
  reg flag_ctrl;
  reg [7:0] shadow_key_byte;
  reg [7:0] data_port_wr;
  reg [7:0] key_control_port;
  reg [21:0] per_cnt;
  reg per_tick;
  reg [21:0] per_limit;
  reg [7:0] next_rdata;

  // decoded fields
  wire [3:0] config_switch;
  wire matrix_primary_select;
  wire matrix_scan_type;
  wire [1:0] periodic_rate_sel;
  wire kbd_clock_enable;
  wire [7:0] serial_byte;
  wire serial_done;
  wire keydown;
  wire sense_down;
  wire drive_down;
  wire [7:0] sense_c;
  wire [7:0] nmi_status;
  wire [7:0] switch_status;

  // access strobes
  wire wr_setup;
  wire wr_nmi;
  wire wr_shadow;
  wire wr_data;
  wire wr_ctrl;
  wire rd_data;

  assign config_switch = scan_setup[`KBN_SW_HI:`KBN_SW_LO];
  assign matrix_primary_select = scan_setup[`KBN_PRIMARY_BIT];
  assign matrix_scan_type = scan_setup[`KBN_SCAN_TYPE_BIT];
  assign periodic_rate_sel = scan_setup[`KBN_RATE_HI:`KBN_RATE_LO];
  assign kbd_clock_enable = key_control_port[`KBN_KCLK_EN_BIT];

  // address decode
  assign wr_setup = wr_i & ~io_space_i & (addr_i == `KBN_IDX_SCAN_SETUP);
  assign wr_nmi = wr_i & ~io_space_i & (addr_i == `KBN_IDX_NMI_CTRL);
  assign wr_shadow = wr_i & ~io_space_i & (addr_i == `KBN_IDX_SHADOW);
  assign wr_data = wr_i & io_space_i & (addr_i == `KBN_IO_DATA_PORT);
  assign wr_ctrl = wr_i & io_space_i & (addr_i == `KBN_IO_CTRL_PORT);
  assign rd_data = rd_i & io_space_i & (addr_i == `KBN_IO_DATA_PORT);

  // sense status C: unassigned bits read one
  assign sense_c = sense_lines_i[23:16] | ~sense_assign_i[23:16];

  // legacy switch port shows the stored switches in the low nibble
  assign switch_status = {4'h0, config_switch};

  // keydown conditions, taken as levels
  assign sense_down = |(~sense_lines_i & sense_assign_i);
  assign drive_down = |(drive_lines_i & drive_assign_i);
  assign keydown = matrix_scan_type ? drive_down : sense_down;

  // status view of the nmi register, reserved bits read zero
  assign nmi_status = {flag_key, flag_per, flag_ctrl, 1'b0, en_key, en_per, en_ctrl, 1'b0};

  // keyboard clock is open drain: pulled low while clock enable is low
  assign serial_kbd_clk_o = 1'b0;
  assign serial_kbd_clk_oe_o = ~kbd_clock_enable;

  // any active source drives the nmi
  assign nmi_o = flag_key | flag_per | flag_ctrl;

  // serial receiver stays active in both modes
  kbn_serial_rx #(.BITS(8)) kbn_serial_rx_inst
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .enable_i(kbd_clock_enable),
    .kbd_clk_i(serial_kbd_clk_i),
    .kbd_data_i(serial_kbd_data_i),
    .byte_o(serial_byte),
    .done_o(serial_done)
  );

  // rate field selects the periodic divide count
  always @*
  begin
    case (periodic_rate_sel)
      2'b00: per_limit = RATE0_CYC[21:0];
      2'b01: per_limit = RATE1_CYC[21:0];
      2'b10: per_limit = RATE2_CYC[21:0];
      2'b11: per_limit = RATE3_CYC[21:0];
      default: per_limit = RATE0_CYC[21:0];
    endcase
  end

  // free running periodic divider, independent of scan type or enable
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      per_cnt <= 22'h000000;
      per_tick <= 1'b0;
    end
    else if (per_cnt >= per_limit - 22'h000001)
    begin
      per_cnt <= 22'h000000;
      per_tick <= 1'b1;
    end
    else
    begin
      per_cnt <= per_cnt + 22'h000001;
      per_tick <= 1'b0;
    end
  end

  // configuration register
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      scan_setup <= `KBN_SETUP_RST;
    end
    else if (wr_setup)
    begin
      scan_setup <= wdata_i;
    end
  end

  // nmi enables
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      en_key <= 1'b0;
      en_per <= 1'b0;
      en_ctrl <= 1'b0;
    end
    else if (wr_nmi)
    begin
      en_key <= wdata_i[`KBN_KEY_EN_BIT];
      en_per <= wdata_i[`KBN_PER_EN_BIT];
      en_ctrl <= wdata_i[`KBN_CTRL_EN_BIT];
    end
  end

  // keydown flag: held while the key is down, clear only when it is up
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      flag_key <= 1'b0;
    end
    else if (en_key & keydown)
    begin
      flag_key <= 1'b1;
    end
    else if (wr_nmi & wdata_i[`KBN_KEY_FLAG_BIT] & ~keydown)
    begin
      flag_key <= 1'b0;
    end
  end

  // periodic flag: a tick in the clearing cycle wins
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      flag_per <= 1'b0;
    end
    else if (en_per & per_tick)
    begin
      flag_per <= 1'b1;
    end
    else if (wr_nmi & wdata_i[`KBN_PER_FLAG_BIT])
    begin
      flag_per <= 1'b0;
    end
  end

  // control port write flag on a low to high move of clock enable
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      flag_ctrl <= 1'b0;
    end
    else if (en_ctrl & wr_ctrl & ~kbd_clock_enable & wdata_i[`KBN_KCLK_EN_BIT])
    begin
      flag_ctrl <= 1'b1;
    end
    else if (wr_nmi & wdata_i[`KBN_CTRL_FLAG_BIT])
    begin
      flag_ctrl <= 1'b0;
    end
  end

  // key control port
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      key_control_port <= `KBN_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      key_control_port <= wdata_i;
    end
  end

  // data port write latch, used only with matrix primary
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      data_port_wr <= `KBN_DATA_RST;
    end
    else if (wr_data & matrix_primary_select)
    begin
      data_port_wr <= wdata_i;
    end
  end

  // shadow byte: serial data when matrix primary, port writes otherwise
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      shadow_key_byte <= `KBN_SHADOW_RST;
    end
    else if (matrix_primary_select & serial_done)
    begin
      shadow_key_byte <= serial_byte;
    end
    else if (~matrix_primary_select & wr_data)
    begin
      shadow_key_byte <= wdata_i;
    end
    else if (wr_shadow)
    begin
      shadow_key_byte <= wdata_i;
    end
  end

  // keyboard irq: set by the primary source, cleared by a data port read
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      keyboard_irq_o <= 1'b0;
    end
    else if (~matrix_primary_select & serial_done)
    begin
      keyboard_irq_o <= 1'b1;
    end
    else if (matrix_primary_select & wr_data)
    begin
      keyboard_irq_o <= 1'b1;
    end
    else if (rd_data)
    begin
      keyboard_irq_o <= 1'b0;
    end
  end

  // read multiplexer
  always @*
  begin
    next_rdata = `KBN_UNMAPPED_RD;
    if (io_space_i)
    begin
      case (addr_i)
        `KBN_IO_DATA_PORT: next_rdata = matrix_primary_select ? data_port_wr : serial_byte;
        `KBN_IO_CTRL_PORT: next_rdata = key_control_port;
        `KBN_IO_SWITCH_PORT: next_rdata = switch_status;
        default: next_rdata = `KBN_UNMAPPED_RD;
      endcase
    end
    else
    begin
      case (addr_i)
        `KBN_IDX_SENSE_C: next_rdata = sense_c;
        `KBN_IDX_SCAN_SETUP: next_rdata = scan_setup;
        `KBN_IDX_NMI_CTRL: next_rdata = nmi_status;
        `KBN_IDX_SHADOW: next_rdata = shadow_key_byte;
        default: next_rdata = `KBN_UNMAPPED_RD;
      endcase
    end
  end

  // registered read data, loaded on a read strobe
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_i)
    begin
      rdata_o <= next_rdata;
    end
  end

endmodule // kbn_keyboard_scan_nmi_control

// >>> logic/kbn_serial_rx.v
// serial keyboard receiver: start bit plus eight data bits, lsb first
`timescale 1ns/10ps
`include "kbn_consts.vh"
module kbn_serial_rx
#(
  parameter BITS = `KBN_RX_BITS
)
(
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // line levels and enable
  input wire enable_i,
  input wire kbd_clk_i,
  input wire kbd_data_i,
  // received character
  output reg [BITS-1:0] byte_o,
  output reg done_o
);

  reg clk_prev;
  reg [3:0] bit_cnt;
  reg [BITS-1:0] shift;
  wire clk_fall;

  // data is taken on the falling edge of the keyboard clock
  assign clk_fall = clk_prev & ~kbd_clk_i;

  // frame tracking and shifting
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      clk_prev <= 1'b1;
      bit_cnt <= 4'h0;
      shift <= {BITS{1'b0}};
      byte_o <= {BITS{1'b0}};
      done_o <= 1'b0;
    end
    else
    begin
      clk_prev <= kbd_clk_i;
      done_o <= 1'b0;
      if (!enable_i)
      begin
        bit_cnt <= 4'h0; // keyboard held in reset, drop any partial frame
      end
      else if (clk_fall)
      begin
        if (bit_cnt == 4'h0)
        begin
          if (kbd_data_i)
          begin
            bit_cnt <= 4'h1; // start bit seen
          end
        end
        else
        begin
          shift <= {kbd_data_i, shift[BITS-1:1]};
          if (bit_cnt == BITS[3:0])
          begin
            byte_o <= {kbd_data_i, shift[BITS-1:1]};
            done_o <= 1'b1;
            bit_cnt <= 4'h0;
          end
          else
          begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
      end
    end
  end

endmodule // kbn_serial_rx

// >>> tb/kbn_assertions.sv
// port checker for the keyboard scan and nmi block
`timescale 1ns/10ps
module kbn_checker
#(
  parameter LINES = 24
)
(
  // clock, reset, register access
  input wire mclk_i,
  input wire rstn_i,
  input wire io_space_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  // matrix and serial lines
  input wire [LINES-1:0] sense_lines_i,
  input wire [LINES-1:0] sense_assign_i,
  input wire [LINES-1:0] drive_lines_i,
  input wire [LINES-1:0] drive_assign_i,
  input wire serial_kbd_clk_i,
  input wire serial_kbd_clk_o,
  input wire serial_kbd_clk_oe_o,
  input wire serial_kbd_data_i,
  // interrupts
  input wire keyboard_irq_o,
  input wire nmi_o
);
  reg [7:0] setup;
  reg [3:1] en;
  wire wr_idx = wr_i && !io_space_i;
  wire wr_io = wr_i && io_space_i;
  wire key_down = setup[2] ? |(drive_lines_i & drive_assign_i) :
    |(~sense_lines_i & sense_assign_i);
  // copies of setup and nmi enables
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      setup <= 8'h00;
      en <= 3'h0;
    end
    else if (wr_idx && addr_i == 8'h66)
      setup <= wdata_i;
    else if (wr_idx && addr_i == 8'h67)
      en <= wdata_i[3:1];
  end
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  clk_hold_a:
    assert property (wr_io && addr_i == 8'h61 |=> serial_kbd_clk_oe_o == !$past(wdata_i[6]))
    else $error("clock hold wrong");
  sense_read_a:
    assert property (rd_i && !io_space_i && addr_i == 8'h65 |=>
      rdata_o == ($past(sense_lines_i[23:16]) | ~$past(sense_assign_i[23:16])))
    else $error("sense status wrong");
  switch_read_a:
    assert property (rd_i && io_space_i && addr_i == 8'h62 |=> rdata_o == {4'h0, $past(setup[7:4])})
    else $error("switch port wrong");
  matrix_irq_a:
    assert property (setup[3] && wr_io && addr_i == 8'h60 |=> keyboard_irq_o)
    else $error("data write irq missing");
  keydown_nmi_a:
    assert property (en[3] && key_down |=> nmi_o)
    else $error("keydown nmi missing");
  clear_all_a:
    assert property (wr_idx && addr_i == 8'h67 && wdata_i[7:5] == 3'h7 && wdata_i[3:1] == 3'h0
      && en == 3'h0 && !key_down |=> !nmi_o)
    else $error("nmi not cleared");
  ctrl_nmi_a:
    assert property (en[1] && wr_io && addr_i == 8'h61 && wdata_i[6] && serial_kbd_clk_oe_o |=> nmi_o)
    else $error("control write nmi missing");
  nmi_fall_a:
    assert property ($fell(nmi_o) |-> $past(wr_idx && addr_i == 8'h67))
    else $error("nmi fell without clear");
endmodule // kbn_checker

// >>> tb/kbn_keyboard_scan_nmi_control_tb.sv
// self-checking bench for the keyboard scan and nmi block
`timescale 1ns/10ps
module kbn_keyboard_scan_nmi_control_tb;
  localparam integer RC [0:3] = '{40, 32, 24, 16};
  reg mclk, rstn, io, wr_en, rd_en;
  reg [7:0] addr, wdata;
  reg [23:0] sl, sa, dl, da;
  wire [7:0] rdata;
  wire kclk, kdata, clk_o, clk_oe, irq, nmi, kclk_wire;
  integer mismatches, num_checks, cyc, t0, r;
  // open-drain keyboard clock
  assign kclk_wire = (clk_oe && !clk_o) ? 1'b0 : kclk;
  kbn_keyboard_scan_nmi_control #(.LINES(24), .RATE0_CYC(RC[0]), .RATE1_CYC(RC[1]),
    .RATE2_CYC(RC[2]), .RATE3_CYC(RC[3])) kbn_keyboard_scan_nmi_control_inst (
    .mclk_i(mclk), .rstn_i(rstn), .io_space_i(io), .addr_i(addr), .wr_i(wr_en),
    .rd_i(rd_en), .wdata_i(wdata), .rdata_o(rdata), .sense_lines_i(sl),
    .sense_assign_i(sa), .drive_lines_i(dl), .drive_assign_i(da),
    .serial_kbd_clk_i(kclk_wire), .serial_kbd_clk_o(clk_o), .serial_kbd_clk_oe_o(clk_oe),
    .serial_kbd_data_i(kdata), .keyboard_irq_o(irq), .nmi_o(nmi));
  kbn_serial_kbd_model kbn_serial_kbd_model_inst (.mclk_i(mclk), .kclk_o(kclk),
    .kdata_o(kdata));
  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // cycle count for period checks
  always @(posedge mclk)
    cyc <= cyc + 1;
  // byte compare
  task chk(input string n, input [7:0] e, input [7:0] g);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  // register write, strobe dropped before the next access
  task wr(input i, input [7:0] a, input [7:0] d);
  begin
    io = i;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge mclk);
    #1 wr_en = 1'b0;
    @(posedge mclk);
    #1;
  end
  endtask
  // register read and compare
  task rd(input i, input [7:0] a, input [7:0] e, input string n);
  begin
    io = i;
    addr = a;
    rd_en = 1'b1;
    @(posedge mclk);
    #1 rd_en = 1'b0;
    chk(n, e, rdata);
    @(posedge mclk);
    #1;
  end
  endtask
  // bounded wait for nmi
  task wait_nmi;
    integer c;
    begin
      c = 0;
      while (nmi !== 1'b1 && c < 200)
      begin
        @(posedge mclk);
        #1 c = c + 1;
      end
      chk("nmi wait", 8'h01, {7'h0, nmi});
    end
  endtask
  // reset values, sense status and switches
  task t_regs;
  begin
    rd(0, 8'h65, 8'hFF, "sense c");
    rd(0, 8'h67, 8'h00, "nmi status");
    rd(0, 8'h69, 8'h00, "unmapped");
    chk("clock hold", 8'h01, {7'h0, clk_oe});
    chk("clock line", 8'h00, {7'h0, kclk_wire});
    sa[23:16] = 8'h0F;
    sl[23:16] = 8'hF5;
    rd(0, 8'h65, 8'hF5, "sense c");
    sl = 24'hFFFFFF;
    sa = 24'h000000;
    wr(0, 8'h66, 8'hA0);
    rd(0, 8'h66, 8'hA0, "setup");
    rd(1, 8'h62, 8'h0A, "switch port");
    wr(0, 8'h66, 8'h00);
  end
  endtask
  // serial keyboard as primary
  task t_serial;
  begin
    wr(1, 8'h61, 8'h40);
    chk("clock hold", 8'h00, {7'h0, clk_oe});
    rd(1, 8'h61, 8'h40, "control port");
    kbn_serial_kbd_model_inst.send(8'h5A, 2);
    chk("irq", 8'h01, {7'h0, irq});
    rd(1, 8'h60, 8'h5A, "data port");
    wr(1, 8'h60, 8'h33);
    rd(1, 8'h60, 8'h5A, "data port");
    rd(0, 8'h68, 8'h33, "shadow");
    wr(0, 8'h68, 8'h77);
    rd(0, 8'h68, 8'h77, "shadow");
  end
  endtask
  // matrix as primary
  task t_matrix;
  begin
    wr(0, 8'h66, 8'h08);
    wr(1, 8'h60, 8'h1C);
    chk("irq", 8'h01, {7'h0, irq});
    rd(1, 8'h60, 8'h1C, "data port");
    kbn_serial_kbd_model_inst.send(8'hC3, 5);
    chk("irq", 8'h00, {7'h0, irq});
    rd(0, 8'h68, 8'hC3, "shadow");
  end
  endtask
  // keydown nmi in both scan types
  task t_keydown;
  begin
    sa[0] = 1'b1;
    sl[0] = 1'b0;
    wr(0, 8'h67, 8'h08);
    rd(0, 8'h67, 8'h88, "nmi status");
    wr(0, 8'h67, 8'h88);
    rd(0, 8'h67, 8'h88, "nmi status");
    chk("nmi", 8'h01, {7'h0, nmi});
    wr(0, 8'h67, 8'h00);
    wr(0, 8'h67, 8'h80);
    rd(0, 8'h67, 8'h80, "nmi status");
    sl[0] = 1'b1;
    wr(0, 8'h67, 8'hE0);
    rd(0, 8'h67, 8'h00, "nmi status");
    wr(0, 8'h66, 8'h0C);
    sl[0] = 1'b0;
    wr(0, 8'h67, 8'h08);
    rd(0, 8'h67, 8'h08, "nmi status");
    da[0] = 1'b1;
    dl[0] = 1'b1;
    wr(0, 8'h67, 8'h08);
    rd(0, 8'h67, 8'h88, "nmi status");
    sl[0] = 1'b1;
    dl[0] = 1'b0;
    wr(0, 8'h67, 8'h00);
    wr(0, 8'h67, 8'h80);
  end
  endtask
  // periodic nmi at each rate
  task t_periodic;
  begin
    for (r = 0; r < 4; r = r + 1)
    begin
      wr(0, 8'h67, 8'h40);
      wr(0, 8'h66, {6'h02, r[1:0]});
      wr(0, 8'h67, 8'h04);
      wait_nmi;
      t0 = cyc;
      wr(0, 8'h67, 8'h44);
      wait_nmi;
      chk("period", 8'(RC[r]), 8'(cyc - t0));
    end
    wr(0, 8'h67, 8'h40);
    repeat (50) @(posedge mclk);
    #1;
    chk("nmi", 8'h00, {7'h0, nmi});
  end
  endtask
  // control port write nmi
  task t_ctrl;
  begin
    wr(1, 8'h61, 8'h00);
    chk("clock hold", 8'h01, {7'h0, clk_oe});
    wr(0, 8'h67, 8'h02);
    wr(1, 8'h61, 8'h40);
    rd(0, 8'h67, 8'h22, "nmi status");
    wr(0, 8'h67, 8'h22);
    wr(1, 8'h61, 8'h40);
    rd(0, 8'h67, 8'h02, "nmi status");
    chk("nmi", 8'h00, {7'h0, nmi});
  end
  endtask
  // verdict and end of run
  task wrap_up;
  begin
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // hang guard at 20000 cycles, far beyond the several hundred cycles needed
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  // main sequence
  initial
  begin
    {rstn, io, wr_en, rd_en, addr, wdata} = 0;
    {sl, sa, dl, da} = {24'hFFFFFF, 72'h0};
    {mismatches, num_checks, cyc} = 0;
    repeat (6) @(posedge mclk);
    #1 rstn = 1'b1;
    t_regs;
    t_serial;
    t_matrix;
    t_keydown;
    t_periodic;
    t_ctrl;
    wrap_up;
  end
endmodule // kbn_keyboard_scan_nmi_control_tb
bind kbn_keyboard_scan_nmi_control kbn_checker #(.LINES(LINES)) kbn_checker_inst (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .io_space_i(io_space_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sense_lines_i(sense_lines_i),
  .sense_assign_i(sense_assign_i), .drive_lines_i(drive_lines_i),
  .drive_assign_i(drive_assign_i), .serial_kbd_clk_i(serial_kbd_clk_i),
  .serial_kbd_clk_o(serial_kbd_clk_o), .serial_kbd_clk_oe_o(serial_kbd_clk_oe_o),
  .serial_kbd_data_i(serial_kbd_data_i), .keyboard_irq_o(keyboard_irq_o), .nmi_o(nmi_o));

// >>> tb/kbn_serial_kbd_model.sv
// serial keyboard model sending start bit then eight bits
`timescale 1ns/10ps
module kbn_serial_kbd_model
(
  // clock
  input wire mclk_i,
  // keyboard lines, idle at pull-up level
  output reg kclk_o,
  output reg kdata_o
);
  // idle lines stand high
  initial
  begin
    kclk_o = 1'b1;
    kdata_o = 1'b1;
  end
  // one frame, lsb first; half sets each clock phase in cycles
  task send(input [7:0] b, input integer half);
    reg [8:0] sh;
    integer i;
    begin
      sh = {b, 1'b1};
      for (i = 0; i < 9; i = i + 1)
      begin
        kdata_o = sh[0];
        sh = sh >> 1;
        repeat (half) @(posedge mclk_i);
        #1 kclk_o = 1'b0;
        repeat (half) @(posedge mclk_i);
        #1 kclk_o = 1'b1;
      end
      kdata_o = 1'b1;
    end
  endtask
endmodule // kbn_serial_kbd_model
